// *** rtl/tac_pkg.sv ***
// package of constants and carrier types for the thermal alarm controller
package tac_pkg;
   // widths
   localparam int TAC_TEMP_W = 16;
   // temperature value after reset and in shutdown
   localparam logic [15:0] TAC_TEMP_SENTINEL = 16'h8000;
   // threshold reset values
   localparam logic [15:0] TAC_UPPER_RST = 16'h5000;
   localparam logic [15:0] TAC_LOWER_RST = 16'h4b00;
   // configuration field positions
   localparam int TAC_CFG_SHDN_BIT = 0;
   localparam int TAC_CFG_MODE_BIT = 1;
   localparam int TAC_CFG_POL_BIT = 2;
   localparam int TAC_CFG_DEPTH_LSB = 3;
   localparam logic [7:0] TAC_CFG_RST = 8'h00;
   // fault counts selected by the depth field
   localparam logic [2:0] TAC_DEPTH_1 = 3'h1;
   localparam logic [2:0] TAC_DEPTH_2 = 3'h2;
   localparam logic [2:0] TAC_DEPTH_4 = 3'h4;
   localparam logic [2:0] TAC_DEPTH_6 = 3'h6;
   localparam logic [2:0] TAC_COUNT_RST = 3'h0;

   // register writes and reads from the serial front end
   typedef struct packed {
      logic wr_upper;
      logic wr_lower;
      logic wr_cfg;
      logic rd_any;
      logic [15:0] wdata;
   } tac_host_t;

   // conversion result from the converter
   typedef struct packed {
      logic done;
      logic [15:0] value;
   } tac_conv_t;

   // decoded configuration
   typedef struct packed {
      logic [1:0] depth;
      logic act_high;
      logic int_mode;
      logic shutdown;
   } tac_cfg_t;

   typedef enum logic {TAC_SEEK_UPPER, TAC_SEEK_LOWER} tac_seek_t;
endpackage

// *** rtl/tac_queue.sv ***
// fault queue counter with depth decode
`timescale 1ns/1ps
module tac_queue
   import tac_pkg::*;
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic clear,
   input wire logic step,
   input wire logic fault,
   input wire logic [1:0] depth_sel,
   output logic reached
);
   logic [2:0] count_q, count_d;
   logic [2:0] depth;

   // depth field to a count
   function automatic logic [2:0] tac_depth(input logic [1:0] sel);
      unique case (sel)
         2'h0: tac_depth = TAC_DEPTH_1;
         2'h1: tac_depth = TAC_DEPTH_2;
         2'h2: tac_depth = TAC_DEPTH_4;
         2'h3: tac_depth = TAC_DEPTH_6;
      endcase
   endfunction

   assign depth = tac_depth(depth_sel); // R14

   // count consecutive faults; a good conversion empties the queue, and so does
   // a completed queue, otherwise the opposite search would start part-filled
   always_comb begin
      count_d = count_q;
      if (clear) begin
         count_d = TAC_COUNT_RST;
      end else if (step) begin
         if (!fault) begin
            count_d = TAC_COUNT_RST;
         end else if (count_q + 3'h1 >= depth) begin
            count_d = TAC_COUNT_RST; // R2 R8
         end else begin
            count_d = count_q + 3'h1; // R8
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         count_q <= TAC_COUNT_RST;
      end else begin
         count_q <= count_d;
      end
   end

   // combinational so the alarm moves on the same strobe that completes the queue
   assign reached = step && fault && !clear && (count_q + 3'h1 >= depth);
endmodule // tac_queue

// *** rtl/tac_regs.sv ***
// configuration and threshold storage
`timescale 1ns/1ps
module tac_regs
   import tac_pkg::*;
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire tac_host_t host,
   output logic [15:0] upper_q,
   output logic [15:0] lower_q,
   output tac_cfg_t cfg_q
);
   logic [15:0] upper_d, lower_d;
   tac_cfg_t cfg_d;

   // thresholds keep nine bits, low seven read as zero
   always_comb begin
      upper_d = upper_q;
      lower_d = lower_q;
      cfg_d = cfg_q;
      if (host.wr_upper) begin
         upper_d = {host.wdata[15:7], 7'h00};
      end
      if (host.wr_lower) begin
         lower_d = {host.wdata[15:7], 7'h00};
      end
      if (host.wr_cfg) begin
         cfg_d.shutdown = host.wdata[TAC_CFG_SHDN_BIT];
         cfg_d.int_mode = host.wdata[TAC_CFG_MODE_BIT]; // R17
         cfg_d.act_high = host.wdata[TAC_CFG_POL_BIT]; // R17
         cfg_d.depth = host.wdata[TAC_CFG_DEPTH_LSB +: 2]; // R14
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         upper_q <= TAC_UPPER_RST;
         lower_q <= TAC_LOWER_RST;
         cfg_q <= tac_cfg_t'(TAC_CFG_RST[4:0]);
      end else begin
         upper_q <= upper_d;
         lower_q <= lower_d;
         cfg_q <= cfg_d;
      end
   end
endmodule // tac_regs

// *** rtl/tac_top.sv ***
// thermal alarm controller: fault queue, alarm modes and shutdown
// Behaviour
// R1 - comparator mode: alarm asserts after depth consecutive conversions above upper threshold
// R2 - comparator mode: alarm releases itself after depth conversions below lower threshold
// R3 - upper minus lower threshold forms the comparator hysteresis band
// R4 - interrupt mode starts by searching for an upper fault after queue clear
// R5 - interrupt mode alternates upper and lower fault searches after each release
// R6 - interrupt alarm holds until any register read, which flips the search
// R7 - interrupt mode: queue clear releases alarm and restarts upper search
// R8 - both interrupt fault types need depth consecutive faulting conversions
// R9 - upper threshold write during alarm releases it and restarts upper search
// R10 - shutdown bit set stops conversions and turns the converter off
// R11 - entering shutdown loads temperature value with 8000h
// R12 - temperature reads 8000h after shutdown until first new conversion
// R13 - fault queue held in reset throughout shutdown
// R14 - depth field selects one, two, four or six faults, default one
// R15 - in-tolerance conversion with alarm idle clears the fault queue
// R16 - threshold or configuration write clears the queue and releases the alarm
// R17 - config bit1 picks comparator or interrupt; bit2 picks alarm polarity
// R18 - fault evaluation happens once per single-cycle conversion strobe
`timescale 1ns/1ps
module tac_top
   import tac_pkg::*;
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire tac_host_t host,
   input wire tac_conv_t conv,
   output logic alarm_output,
   output logic conv_enable,
   output logic [15:0] temp_value,
   output logic [15:0] upper_trip_threshold,
   output logic [15:0] lower_release_threshold,
   output logic [7:0] config_value
);
   logic [15:0] upper_w, lower_w;
   tac_cfg_t cfg_w;
   logic alarm_q, alarm_d;
   tac_seek_t seek_q, seek_d;
   logic [15:0] temp_q, temp_d;
   logic pin_q, pin_d;
   logic conv_en_q, conv_en_d;
   logic [15:0] upper_o_q, lower_o_q;
   logic [7:0] cfg_o_q;
   logic q_clear, step, fault, reached;
   logic above, below;

   tac_regs u_regs (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .host(host),
      .upper_q(upper_w),
      .lower_q(lower_w),
      .cfg_q(cfg_w)
   );

   // signed compare of a result against a threshold
   function automatic logic tac_gt(input logic [15:0] a, input logic [15:0] b);
      tac_gt = $signed(a) > $signed(b);
   endfunction

   // conversions are only honoured while running
   assign step = conv.done && !cfg_w.shutdown; // R18 R10
   assign above = tac_gt(conv.value, upper_w);
   assign below = tac_gt(lower_w, conv.value);

   // what counts as a fault depends on mode and alarm state
   always_comb begin
      fault = 1'b0;
      if (!cfg_w.int_mode) begin
         fault = alarm_q ? below : above; // R1 R2 R3
      end else if (!alarm_q) begin
         fault = (seek_q == TAC_SEEK_UPPER) ? above : below; // R5
      end
   end

   // any writing access or shutdown empties the queue; an in-tolerance
   // result with the alarm idle empties it inside the counter
   assign q_clear = host.wr_upper || host.wr_lower || host.wr_cfg
                    || cfg_w.shutdown; // R16 R13 R15

   tac_queue u_queue (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .clear(q_clear),
      .step(step),
      .fault(fault),
      .depth_sel(cfg_w.depth),
      .reached(reached)
   );

   // alarm and search direction
   always_comb begin
      alarm_d = alarm_q;
      seek_d = seek_q;
      if (q_clear) begin
         alarm_d = 1'b0; // R16 R9
         seek_d = TAC_SEEK_UPPER; // R7 R4
      end else if (!cfg_w.int_mode) begin
         if (reached) begin
            alarm_d = !alarm_q; // R1 R2
         end
      end else if (alarm_q) begin
         if (host.rd_any) begin
            alarm_d = 1'b0; // R6
            seek_d = (seek_q == TAC_SEEK_UPPER) ? TAC_SEEK_LOWER : TAC_SEEK_UPPER; // R5
         end
      end else if (reached) begin
         alarm_d = 1'b1; // R8
      end
   end

   // temperature value, sentinel while shut down until a fresh result
   always_comb begin
      temp_d = temp_q;
      if (cfg_w.shutdown) begin
         temp_d = TAC_TEMP_SENTINEL; // R11 R12
      end else if (conv.done) begin
         temp_d = conv.value;
      end
   end

   // outputs all registered; pin polarity applied here
   always_comb begin
      pin_d = cfg_w.act_high ? alarm_d : !alarm_d; // R17
      conv_en_d = !cfg_w.shutdown; // R10
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         alarm_q <= 1'b0;
         seek_q <= TAC_SEEK_UPPER;
         temp_q <= TAC_TEMP_SENTINEL;
         pin_q <= 1'b1;
         conv_en_q <= 1'b1;
         upper_o_q <= TAC_UPPER_RST;
         lower_o_q <= TAC_LOWER_RST;
         cfg_o_q <= TAC_CFG_RST;
      end else begin
         alarm_q <= alarm_d;
         seek_q <= seek_d;
         temp_q <= temp_d;
         pin_q <= pin_d;
         conv_en_q <= conv_en_d;
         upper_o_q <= upper_w;
         lower_o_q <= lower_w;
         cfg_o_q <= {3'h0, cfg_w.depth, cfg_w.act_high, cfg_w.int_mode, cfg_w.shutdown};
      end
   end

   assign alarm_output = pin_q;
   assign conv_enable = conv_en_q;
   assign temp_value = temp_q;
   assign upper_trip_threshold = upper_o_q;
   assign lower_release_threshold = lower_o_q;
   assign config_value = cfg_o_q;
endmodule // tac_top

// *** test/tac_checker.sv ***
// port assertions for the thermal alarm controller
`timescale 1ns/1ps
module tac_checker
   import tac_pkg::*;
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire tac_host_t host,
   input wire tac_conv_t conv,
   input wire logic alarm_output,
   input wire logic conv_enable,
   input wire logic [15:0] temp_value,
   input wire logic [15:0] upper_trip_threshold,
   input wire logic [15:0] lower_release_threshold,
   input wire logic [7:0] config_value
);
   logic wr_any;
   logic quiet;
   logic cmp1;
   // causes of an alarm change; depth-one active-low comparator setup
   assign wr_any = host.wr_upper | host.wr_lower | host.wr_cfg;
   assign quiet = !wr_any && !host.rd_any && !conv.done;
   assign cmp1 = config_value[4:0] == 5'h00 && !wr_any;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   a_shdn_temp: assert property (
      config_value[0] [*2] |-> temp_value == 16'h8000) else $error("temp not sentinel");
   a_shdn_conv: assert property (
      config_value[0] [*2] |-> !conv_enable) else $error("converter runs in shutdown");
   a_temp_load: assert property (
      conv.done && !config_value[0] && !host.wr_cfg |=> temp_value == $past(conv.value))
      else $error("temp not loaded");
   a_wr_release: assert property (
      host.wr_upper || host.wr_lower |=> alarm_output == !config_value[2])
      else $error("write did not release");
   a_rd_release: assert property (
      host.rd_any && config_value[1] && !conv.done && !wr_any |=> alarm_output == !config_value[2])
      else $error("read did not release");
   a_pin_hold: assert property (
      quiet && !$past(host.wr_cfg) |=> $stable(alarm_output)) else $error("alarm moved alone");
   a_cmp_trip: assert property (
      cmp1 && alarm_output && conv.done && $signed(conv.value) > $signed(upper_trip_threshold)
      |=> !alarm_output) else $error("comparator did not trip");
   a_cmp_release: assert property (
      cmp1 && !alarm_output && conv.done
      && $signed(conv.value) < $signed(lower_release_threshold) |=> alarm_output)
      else $error("comparator did not release");
endmodule // tac_checker

bind tac_top tac_checker chk_i (.clk_sys(clk_sys), .resetn(resetn), .host(host), .conv(conv),
   .alarm_output(alarm_output), .conv_enable(conv_enable), .temp_value(temp_value),
   .upper_trip_threshold(upper_trip_threshold),
   .lower_release_threshold(lower_release_threshold), .config_value(config_value));

// *** test/tac_master.sv ***
// behavioural register master and converter feeding the controller
`timescale 1ns/1ps
module tac_master
   import tac_pkg::*;
(
   input wire logic clk_sys,
   output tac_host_t host,
   output tac_conv_t conv
);
   // idle lines at time zero
   initial begin
      host = '0;
      conv = '0;
   end
   // write k: 0 upper, 1 lower, 2 config; one spare cycle lets copies settle
   task automatic wr(input logic [1:0] k, input logic [15:0] d);
      @(negedge clk_sys);
      host = {k == 2'h0, k == 2'h1, k == 2'h2, 1'b0, d};
      @(negedge clk_sys);
      host = {4'h0, ~d}; // released data shows the inverse, never a stale copy
      @(negedge clk_sys);
   endtask
   // read of any register
   task automatic rd();
      @(negedge clk_sys);
      host.rd_any = 1'b1;
      @(negedge clk_sys);
      host.rd_any = 1'b0;
   endtask
   // one conversion result
   task automatic cv(input logic [15:0] v);
      @(negedge clk_sys);
      conv = {1'b1, v};
      @(negedge clk_sys);
      conv = {1'b0, ~v};
   endtask
endmodule // tac_master

// *** test/tb_thermal_alarm_controller.sv ***
// self-checking bench for the thermal alarm controller
`timescale 1ns/1ps
module tb_thermal_alarm_controller;
   import tac_pkg::*;
   localparam logic [15:0] HOT = 16'h5080;
   localparam logic [15:0] COLD = 16'h4a00;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   tac_host_t host;
   tac_conv_t conv;
   logic alarm_output;
   logic conv_enable;
   logic [15:0] temp_value;
   logic [15:0] upper_trip_threshold;
   logic [15:0] lower_release_threshold;
   logic [7:0] config_value;
   int n_mismatch = 0;
   int compares = 0;
   int cycles = 0;
   int dep[4] = '{1, 2, 4, 6};
   // 40 MHz clock
   always #12.5 clk_sys = ~clk_sys;
   tac_master m (.clk_sys(clk_sys), .host(host), .conv(conv));
   tac_top uut (.clk_sys(clk_sys), .resetn(resetn), .host(host), .conv(conv),
      .alarm_output(alarm_output), .conv_enable(conv_enable), .temp_value(temp_value),
      .upper_trip_threshold(upper_trip_threshold),
      .lower_release_threshold(lower_release_threshold), .config_value(config_value));
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic al(input logic e);
      chk("alarm_output", {15'h0, e}, {15'h0, alarm_output});
   endtask
   task automatic print_verdict;
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // hang guard, well above the roughly 130 cycles the sequence needs
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 2000) begin
         n_mismatch++;
         print_verdict();
      end
   end
   // main sequence
   initial begin
      repeat (10) @(negedge clk_sys);
      resetn = 1'b1;
      chk("temp_value", 16'h8000, temp_value);
      chk("upper", 16'h5000, upper_trip_threshold);
      chk("lower", 16'h4b00, lower_release_threshold);
      chk("config", 16'h0000, {8'h00, config_value});
      m.cv(HOT);
      al(1'b0);
      chk("temp_value", HOT, temp_value);
      m.cv(16'h4c00);
      al(1'b0);
      m.cv(COLD);
      al(1'b1);
      // each depth code: n-1 faults leave the pin idle, the n-th trips it
      for (int d = 0; d < 4; d++) begin
         m.wr(2'h2, {11'h000, d[1:0], 3'h0});
         al(1'b1);
         for (int i = 1; i < dep[d]; i++) begin
            m.cv(HOT);
            al(1'b1);
         end
         m.cv(HOT);
         al(1'b0);
      end
      m.wr(2'h2, 16'h0008);
      m.cv(HOT);
      m.cv(16'h4c00);
      m.cv(HOT);
      al(1'b1);
      // depth two in comparator mode: trip needs two, release needs two fresh
      m.cv(HOT);
      al(1'b0);
      m.cv(COLD);
      al(1'b0);
      m.cv(COLD);
      al(1'b1);
      // interrupt mode, active high, depth one
      m.wr(2'h2, 16'h0006);
      m.cv(HOT);
      al(1'b1);
      m.cv(COLD);
      al(1'b1);
      m.rd();
      al(1'b0);
      m.cv(HOT);
      al(1'b0);
      m.cv(COLD);
      al(1'b1);
      m.rd();
      m.cv(HOT);
      al(1'b1);
      m.wr(2'h0, 16'h60ff);
      al(1'b0);
      chk("upper", 16'h6080, upper_trip_threshold);
      m.cv(HOT);
      al(1'b0);
      m.cv(16'h6100);
      al(1'b1);
      m.wr(2'h1, 16'h4bff);
      al(1'b0);
      chk("lower", 16'h4b80, lower_release_threshold);
      m.cv(COLD);
      al(1'b0);
      // interrupt mode, depth two: both fault kinds need two strobes
      m.wr(2'h2, 16'h000e);
      m.cv(16'h6100);
      al(1'b0);
      m.cv(16'h6100);
      al(1'b1);
      m.rd();
      m.cv(COLD);
      al(1'b0);
      m.cv(COLD);
      al(1'b1);
      // shutdown: sentinel, converter off, queue held clear
      m.wr(2'h2, 16'h0001);
      chk("temp_value", 16'h8000, temp_value);
      chk("conv_enable", 16'h0000, {15'h0, conv_enable});
      m.cv(16'h6100);
      chk("temp_value", 16'h8000, temp_value);
      al(1'b1);
      m.wr(2'h2, 16'h0000);
      chk("temp_value", 16'h8000, temp_value);
      chk("conv_enable", 16'h0001, {15'h0, conv_enable});
      m.cv(16'h1900);
      chk("temp_value", 16'h1900, temp_value);
      // raise the alarm, then a mid-run reset must bring alarm, temperature, thresholds and converter enable back
      m.cv(16'h6100);
      al(1'b0);
      @(negedge clk_sys);
      resetn = 1'b0;
      repeat (2) @(negedge clk_sys);
      resetn = 1'b1;
      al(1'b1);
      chk("temp_value", 16'h8000, temp_value);
      chk("upper", 16'h5000, upper_trip_threshold);
      chk("lower", 16'h4b00, lower_release_threshold);
      chk("conv_enable", 16'h0001, {15'h0, conv_enable});
      // first result after reset is judged against the reset threshold
      m.cv(HOT);
      al(1'b0);
      chk("temp_value", HOT, temp_value);
      print_verdict();
   end
endmodule // tb_thermal_alarm_controller
